// ### verilog/spcmd_regs.vh
/*
 * register map and field positions of the switch port command block.
 * assumes inclusion by bare name from the design files.
 */
`ifndef SPCMD_REGS_VH
`define SPCMD_REGS_VH
`define SPCMD_ADDR_W 12
`define SPCMD_OFF_CMD 12'h004
`define SPCMD_OFF_STAT 12'h008
`define SPCMD_OFF_IRQ_STAT 12'h00C
`define SPCMD_OFF_IRQ_MASK 12'h010
`define SPCMD_OFF_ID 12'h014
`define SPCMD_CMD_RST 16'h0000
`define SPCMD_CMD_WMASK 16'h0547
`define SPCMD_BIT_IO 0
`define SPCMD_BIT_MEM 1
`define SPCMD_BIT_BME 2
`define SPCMD_BIT_PERR 6
`define SPCMD_BIT_SERR 8
`define SPCMD_BIT_INTD 10
`define SPCMD_STAT_W 2
`define SPCMD_STAT_MDPE 0
`define SPCMD_STAT_SSE 1
`define SPCMD_EV_W 4
`define SPCMD_EV_UR 0
`define SPCMD_EV_PERR 1
`define SPCMD_EV_ERR 2
`define SPCMD_EV_INTX 3
`define SPCMD_ID_VAL 32'h0000_5A5A
`endif

// ### verilog/spcmd_w1c.v
/*
 * one sticky flag: hardware set, software write-one clear, set wins.
 * assumes an asynchronous active-low reset copy from the parent, released synchronously.
 */
`timescale 1ns/1ns
module spcmd_w1c (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_set,
    input wire i_clr,
    output reg o_q
);
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_q <= 1'b0;
        else if (i_set)
            o_q <= 1'b1;
        else if (i_clr)
            o_q <= 1'b0;
    end
endmodule

// ### verilog/spcmd_gate.v
/*
 * request gating of one port from the command bits, registered.
 * assumes one-cycle request pulses in the i_clk domain.
 */
`timescale 1ns/1ns
module spcmd_gate (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_io_en,
    input wire i_mem_en,
    input wire i_bme,
    input wire i_intd,
    input wire i_pri_io,
    input wire i_pri_mem,
    input wire i_up_req,
    input wire i_up_np,
    input wire i_own_intx,
    input wire i_fwd_intx,
    output reg o_pri_io_acc,
    output reg o_pri_mem_acc,
    output reg o_up_fwd,
    output reg o_up_ur,
    output reg o_ur_cpl,
    output reg o_intx_msg
);
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_pri_io_acc <= 1'b0;
            o_pri_mem_acc <= 1'b0;
            o_up_fwd <= 1'b0;
            o_up_ur <= 1'b0;
            o_ur_cpl <= 1'b0;
            o_intx_msg <= 1'b0;
        end
        else
        begin
            o_pri_io_acc <= i_pri_io & i_io_en;
            o_pri_mem_acc <= i_pri_mem & i_mem_en;
            o_up_fwd <= i_up_req & i_bme;
            o_up_ur <= i_up_req & ~i_bme;
            o_ur_cpl <= i_up_req & i_up_np & ~i_bme;
            // forwarded messages pass regardless of disable
            o_intx_msg <= (i_own_intx & ~i_intd) | i_fwd_intx;
        end
    end
endmodule

// ### verilog/spcmd_top.v
/*
 * switch port command register with apb slave, status flags and
 * request gating for one port.
 * holds the command bits, two write-one-clear status flags, four
 * interrupt event flags with mask, and the level interrupt output.
 * assumes an apb master on i_clk, one-cycle event pulses synchronous
 * to i_clk, and an asynchronous active-low reset on i_nrst.
 */
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
`include "spcmd_regs.vh"
module spcmd_top (
    input wire i_clk,
    input wire i_nrst,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [3:0] i_pstrb,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    input wire i_pri_io,
    input wire i_pri_mem,
    input wire i_up_req,
    input wire i_up_np,
    input wire i_parity_err,
    input wire i_fatal_err,
    input wire i_own_intx,
    input wire i_fwd_intx,
    output wire o_pri_io_acc,
    output wire o_pri_mem_acc,
    output wire o_up_fwd,
    output wire o_up_ur,
    output wire o_ur_cpl,
    output wire o_intx_msg,
    output reg o_err_msg,
    output reg o_perr_act,
    output reg o_irq
);
    // one-hot apb phase codes
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_ACCESS = 2'b10;

    reg rst_s1_q;
    reg rst_n_q;
    reg [1:0] st_q;
    reg [1:0] st_d;
    reg [15:0] cmd_q;
    reg [`SPCMD_EV_W-1:0] mask_q;
    wire [`SPCMD_STAT_W-1:0] stat;
    wire [`SPCMD_EV_W-1:0] ev_flag;
    wire [`SPCMD_EV_W-1:0] ev_set;
    wire [`SPCMD_EV_W-1:0] clr_ev;
    wire setup;
    wire take;
    wire wr;
    wire wr_cmd;
    wire wr_stat;
    wire wr_irq_stat;
    wire wr_mask;
    wire clr_mdpe;
    wire clr_sse;
    wire [7:0] wdat_hi;
    wire [7:0] wdat_lo;
    wire [15:0] wdat;
    wire perr_ok;
    wire err_ok;
    wire own_ok;
    wire [31:0] rd_cmd;
    wire [31:0] rd_stat;
    wire [31:0] rd_irq_stat;
    wire [31:0] rd_mask;
    reg [31:0] rdata_d;
    reg err_d;

    // reset release through two flops
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // apb phase tracker: setup is answered in the next cycle
    assign setup = i_psel & ~i_penable;
    assign take = setup & (st_q == ST_IDLE);
    assign wr = i_psel & i_penable & i_pwrite & (st_q == ST_ACCESS);

    always @(posedge i_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            st_q <= ST_IDLE;
        else
            st_q <= st_d;
    end

    always @*
    begin
        st_d = st_q;
        case (st_q)
            ST_IDLE:
            begin
                if (setup)
                    st_d = ST_ACCESS;
            end
            ST_ACCESS:
                st_d = ST_IDLE;
            default:
                st_d = ST_IDLE;
        endcase
    end

    // write decode per register
    assign wr_cmd = wr & (i_paddr == `SPCMD_OFF_CMD);
    assign wr_stat = wr & (i_paddr == `SPCMD_OFF_STAT) & i_pstrb[0];
    assign wr_irq_stat = wr & (i_paddr == `SPCMD_OFF_IRQ_STAT) & i_pstrb[0];
    assign wr_mask = wr & (i_paddr == `SPCMD_OFF_IRQ_MASK) & i_pstrb[0];
    assign clr_mdpe = wr_stat & i_pwdata[`SPCMD_STAT_MDPE];
    assign clr_sse = wr_stat & i_pwdata[`SPCMD_STAT_SSE];
    assign clr_ev = {`SPCMD_EV_W{wr_irq_stat}} & i_pwdata[`SPCMD_EV_W-1:0];

    // byte lanes: strobe picks new or old byte
    assign wdat_hi = i_pstrb[1] ? i_pwdata[15:8] : cmd_q[15:8];
    assign wdat_lo = i_pstrb[0] ? i_pwdata[7:0] : cmd_q[7:0];
    assign wdat = {wdat_hi, wdat_lo};

    // qualified events
    assign perr_ok = i_parity_err & cmd_q[`SPCMD_BIT_PERR];
    assign err_ok = i_fatal_err & cmd_q[`SPCMD_BIT_SERR];
    assign own_ok = i_own_intx & ~cmd_q[`SPCMD_BIT_INTD];

    // read values, unused bits read zero
    assign rd_cmd = {16'h0000, cmd_q};
    assign rd_stat = {{(32-`SPCMD_STAT_W){1'b0}}, stat};
    assign rd_irq_stat = {{(32-`SPCMD_EV_W){1'b0}}, ev_flag};
    assign rd_mask = {{(32-`SPCMD_EV_W){1'b0}}, mask_q};

    // register map decode and read mux
    always @*
    begin
        rdata_d = 32'h0000_0000;
        err_d = 1'b0;
        case (i_paddr)
            `SPCMD_OFF_CMD: rdata_d = rd_cmd;
            `SPCMD_OFF_STAT: rdata_d = rd_stat;
            `SPCMD_OFF_IRQ_STAT: rdata_d = rd_irq_stat;
            `SPCMD_OFF_IRQ_MASK: rdata_d = rd_mask;
            `SPCMD_OFF_ID: rdata_d = `SPCMD_ID_VAL; // arbitrary value
            default: err_d = 1'b1;
        endcase
    end

    // one-cycle answer pulse
    always @(posedge i_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            o_pready <= 1'b0;
        else
            o_pready <= take;
    end

    // error flag for unmapped addresses
    always @(posedge i_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            o_pslverr <= 1'b0;
        else
            o_pslverr <= take & err_d;
    end

    // read data stands only in the answer cycle
    always @(posedge i_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            o_prdata <= 32'h0000_0000;
        else if (take & ~i_pwrite)
            o_prdata <= rdata_d;
        else
            o_prdata <= 32'h0000_0000;
    end

    // command register, legacy and reserved bits held at zero
    always @(posedge i_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            cmd_q <= `SPCMD_CMD_RST;
        else if (wr_cmd)
            cmd_q <= wdat & `SPCMD_CMD_WMASK;
    end

    // interrupt mask
    always @(posedge i_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            mask_q <= {`SPCMD_EV_W{1'b0}};
        else if (wr_mask)
            mask_q <= i_pwdata[`SPCMD_EV_W-1:0];
    end

    // error report pulse
    always @(posedge i_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            o_err_msg <= 1'b0;
        else
            o_err_msg <= err_ok;
    end

    // parity handling pulse
    always @(posedge i_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            o_perr_act <= 1'b0;
        else
            o_perr_act <= perr_ok;
    end

    // level interrupt from unmasked flags
    always @(posedge i_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            o_irq <= 1'b0;
        else
            o_irq <= |(ev_flag & mask_q);
    end

    // status flags, write one to clear
    spcmd_w1c u_mdpe (
        .i_clk(i_clk),
        .i_rst_n(rst_n_q),
        .i_set(perr_ok),
        .i_clr(clr_mdpe),
        .o_q(stat[`SPCMD_STAT_MDPE])
    );
    spcmd_w1c u_sse (
        .i_clk(i_clk),
        .i_rst_n(rst_n_q),
        .i_set(err_ok),
        .i_clr(clr_sse),
        .o_q(stat[`SPCMD_STAT_SSE])
    );

    // interrupt event flags
    assign ev_set = {own_ok, err_ok, perr_ok, o_up_ur};
    genvar g;
    generate
        for (g = 0; g < `SPCMD_EV_W; g = g + 1)
        begin : g_ev
            spcmd_w1c u_ev (
                .i_clk(i_clk),
                .i_rst_n(rst_n_q),
                .i_set(ev_set[g]),
                .i_clr(clr_ev[g]),
                .o_q(ev_flag[g])
            );
        end
    endgenerate

    // request gating from the command bits
    spcmd_gate u_gate (
        .i_clk(i_clk),
        .i_rst_n(rst_n_q),
        .i_io_en(cmd_q[`SPCMD_BIT_IO]),
        .i_mem_en(cmd_q[`SPCMD_BIT_MEM]),
        .i_bme(cmd_q[`SPCMD_BIT_BME]),
        .i_intd(cmd_q[`SPCMD_BIT_INTD]),
        .i_pri_io(i_pri_io),
        .i_pri_mem(i_pri_mem),
        .i_up_req(i_up_req),
        .i_up_np(i_up_np),
        .i_own_intx(i_own_intx),
        .i_fwd_intx(i_fwd_intx),
        .o_pri_io_acc(o_pri_io_acc),
        .o_pri_mem_acc(o_pri_mem_acc),
        .o_up_fwd(o_up_fwd),
        .o_up_ur(o_up_ur),
        .o_ur_cpl(o_ur_cpl),
        .o_intx_msg(o_intx_msg)
    );
endmodule

// ### tb/spcmd_host.sv
/* host side event source for the command block.
   assumes the bench asks one cycle ahead. */
`timescale 1ns/1ns
module spcmd_host (
    input wire i_clk,
    input wire [7:0] i_kick,
    output reg [7:0] o_ev
);
    // one-cycle pulses, launched one edge after the ask
    always @(posedge i_clk)
    begin
        o_ev <= i_kick;
    end
endmodule

// ### tb/spcmd_checker.sv
/* port checker of the command block.
   assumes bind onto spcmd_top. */
`timescale 1ns/1ns
module spcmd_checker (
    input wire i_clk,
    input wire i_nrst,
    input wire i_pri_io,
    input wire i_up_req,
    input wire i_up_np,
    input wire i_parity_err,
    input wire i_fatal_err,
    input wire i_own_intx,
    input wire i_fwd_intx,
    input wire o_pri_io_acc,
    input wire o_up_fwd,
    input wire o_up_ur,
    input wire o_ur_cpl,
    input wire o_intx_msg,
    input wire o_err_msg,
    input wire o_perr_act
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_np_ur; i_up_req && i_up_np ##1 o_up_ur; endsequence
    property p_io; o_pri_io_acc |-> $past(i_pri_io); endproperty
    property p_up; (o_up_fwd | o_up_ur) == $past(i_up_req)
        && !(o_up_fwd && o_up_ur); endproperty
    property p_cpl; s_np_ur |-> o_ur_cpl; endproperty
    property p_cpl_src; o_ur_cpl |-> o_up_ur && $past(i_up_np); endproperty
    property p_err; o_err_msg |-> $past(i_fatal_err); endproperty
    property p_perr; o_perr_act |-> $past(i_parity_err); endproperty
    property p_own; o_intx_msg |-> $past(i_own_intx || i_fwd_intx);
    endproperty
    property p_fwd; i_fwd_intx |=> o_intx_msg; endproperty
    a_io: assert property (p_io) else $error("io accept");
    a_up: assert property (p_up) else $error("upstream");
    a_cpl: assert property (p_cpl) else $error("ur cpl");
    a_cpl_src: assert property (p_cpl_src) else $error("cpl src");
    a_err: assert property (p_err) else $error("err msg");
    a_perr: assert property (p_perr) else $error("perr");
    a_own: assert property (p_own) else $error("intx src");
    a_fwd: assert property (p_fwd) else $error("intx fwd");
endmodule
bind spcmd_top spcmd_checker u_chk (.*);

// ### tb/switch_port_command_register_bench.sv
/* self-checking bench of the command block over apb.
   assumes spcmd_top, spcmd_host and the checker. */
`timescale 1ns/1ns
`include "spcmd_regs.vh"
module switch_port_command_register_bench;
    reg i_clk = 0, i_nrst = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
    reg [11:0] i_paddr = 0;
    reg [31:0] i_pwdata = 0, r;
    reg [3:0] i_pstrb = 4'hf;
    reg [7:0] kick = 0, x;
    reg [15:0] c;
    reg er;
    wire [7:0] ev;
    wire [31:0] o_prdata;
    wire o_pready, o_pslverr, o_pri_io_acc, o_pri_mem_acc, o_up_fwd;
    wire o_up_ur, o_ur_cpl, o_intx_msg, o_err_msg, o_perr_act, o_irq;
    integer fail_count = 0, check_count = 0, cyc = 0, k, j;
    spcmd_host host (.i_clk(i_clk), .i_kick(kick), .o_ev(ev));
    spcmd_top dut (.i_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite,
        .i_paddr, .i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr,
        .i_pri_io(ev[0]), .i_pri_mem(ev[1]), .i_up_req(ev[2]),
        .i_up_np(ev[3]), .i_parity_err(ev[4]), .i_fatal_err(ev[5]),
        .i_own_intx(ev[6]), .i_fwd_intx(ev[7]), .o_pri_io_acc,
        .o_pri_mem_acc, .o_up_fwd, .o_up_ur, .o_ur_cpl, .o_intx_msg,
        .o_err_msg, .o_perr_act, .o_irq);
    always #50 i_clk = ~i_clk;
    task wrap_up;
    begin
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask
    always @(posedge i_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            fail_count = fail_count + 1;
            wrap_up;
        end
    end
    task chk(input [31:0] s, input [31:0] e, input string n);
    begin
        check_count = check_count + 1;
        if (s !== e)
        begin
            fail_count = fail_count + 1;
            $display("mismatch %s exp %h saw %h", n, e, s);
        end
    end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
    begin
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        @(posedge i_clk);
        while (o_pready !== 1'b1)
            @(posedge i_clk);
        r = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk);
    end
    endtask
    task fire(input [7:0] e);
    begin
        x = {e[6] & ~c[10] | e[7], e[4] & c[6], e[5] & c[8],
            e[2] & e[3] & ~c[2], e[2] & ~c[2], e[2] & c[2],
            e[1] & c[1], e[0] & c[0]};
        kick <= e;
        @(posedge i_clk);
        kick <= 8'h00;
        @(posedge i_clk);
        #1;
        chk({o_intx_msg, o_perr_act, o_err_msg, o_ur_cpl, o_up_ur,
            o_up_fwd, o_pri_mem_acc, o_pri_io_acc}, x, "gate");
        @(posedge i_clk);
    end
    endtask
    initial
    begin
        repeat (16) @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_clk);
        apb(0, `SPCMD_OFF_CMD, 0);
        chk(r, 0, "cmd rst");
        apb(0, 12'h020, 0);
        chk(er, 1, "unmapped err");
        chk(r, 0, "unmapped data");
        apb(0, `SPCMD_OFF_ID, 0);
        chk(r, `SPCMD_ID_VAL, "id");
        for (k = 0; k < 3; k = k + 1)
        begin
            c = k == 0 ? 16'h0000 : k == 1 ? 16'hffff : 16'h0405;
            apb(1, `SPCMD_OFF_CMD, {16'h0000, c});
            apb(0, `SPCMD_OFF_CMD, 0);
            c = c & `SPCMD_CMD_WMASK;
            chk(r, c, "cmd");
            for (j = 0; j < 3; j = j + 1)
                fire(j == 0 ? 8'hff : j == 1 ? 8'h44 : 8'h80);
            apb(0, `SPCMD_OFF_STAT, 0);
            chk(r, {c[8], c[6]}, "stat");
            apb(1, `SPCMD_OFF_STAT, 32'h0000_0003);
        end
        i_pstrb <= 4'h1;
        apb(1, `SPCMD_OFF_CMD, 32'h0000_0000);
        i_pstrb <= 4'hf;
        apb(0, `SPCMD_OFF_CMD, 0);
        chk(r, 32'h0000_0400, "cmd lane");
        apb(0, `SPCMD_OFF_IRQ_STAT, 0);
        chk(r, 32'h0000_000f, "irq stat");
        chk(o_irq, 0, "irq masked");
        apb(1, `SPCMD_OFF_IRQ_MASK, 32'h0000_0004);
        @(posedge i_clk);
        #1;
        chk(o_irq, 1, "irq");
        apb(1, `SPCMD_OFF_IRQ_STAT, 32'h0000_0004);
        @(posedge i_clk);
        #1;
        chk(o_irq, 0, "irq clr");
        wrap_up;
    end
endmodule
